// ### logic/async_serial_pkg.sv
// Constants shared by the asynchronous serial port core.
// Contract
// - Each completed character moves from the receive shifter into the receive buffer unless the buffer is still full.
// - Seven-bit characters fill buffer bits 0 to 6; bit 7 reads zero.
// - On overrun the buffer keeps its contents and the new character is dropped.
// - Receive buffer is read-only; reset or power gate off sets it to all ones.
// - Writing the transmit shift register starts sending that character on the output pin.
// - Transmit shift register is write-only; reset, power off or transmit disable set ones.
// - Power gate bit 7 cleared asynchronously resets status, transmit and receive registers.
// - While power gate is off the receive input is seen as high.
// - Transmit enable bit 6 and receive enable bit 5 reset their halves, synced to base clock.
// - Parity field bits 4:3: none, zero, odd, even; same for send and check.
// - Zero parity reception never checks parity, so parity error never sets.
// - Length bit 2 selects seven data bits at 0 and eight at 1.
// - Stop bit 1 gives one or two transmit stop bits; receiver always uses one.
// - Enabling reception while the input is low starts reception immediately.
// - Error status holds three flags, cleared by reset, power off or receive disable.
// - Characters travel least significant bit first.
// - Bit rate is the five-bit divider output divided by two.
// - Framing error sets when the first stop position is not sampled high.
// - Overrun sets when a character completes while the buffer is still unread.
package async_serial_pkg;
   localparam int        ADDR_W        = 16;
   localparam int        DIV_W         = 5;
   localparam int        FRAME_W       = 12;
   localparam int        BITS_W        = 4;

   localparam logic [15:0] MODE_ADDR   = 16'hff70;
   localparam logic [15:0] DATA_ADDR   = 16'hff72;
   localparam logic [15:0] STATUS_ADDR = 16'hff73;

   localparam logic [7:0] MODE_RESET    = 8'h01;
   localparam logic [7:0] RXBUF_RESET   = 8'hff;
   localparam logic [7:0] TXSHIFT_RESET = 8'hff;
   localparam logic [7:0] STATUS_RESET  = 8'h00;
   localparam logic [7:0] READ_NONE     = 8'h00;

   localparam int POWER_BIT = 7;
   localparam int TXE_BIT   = 6;
   localparam int RXE_BIT   = 5;
   localparam int PAR_HI    = 4;
   localparam int PAR_LO    = 3;
   localparam int CLEN_BIT  = 2;
   localparam int STOP_BIT  = 1;

   localparam int PE_BIT  = 2;
   localparam int FE_BIT  = 1;
   localparam int OVE_BIT = 0;

   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   localparam logic [4:0] DIV_MIN     = 5'h08;
   localparam logic [3:0] LEN_SEVEN   = 4'h7;
   localparam logic [3:0] LEN_EIGHT   = 4'h8;
endpackage

// ### logic/bit_timer.sv
// Bit period timer: a divide-by-k counter on base ticks, halved again for the bit rate.
module bit_timer #(
   parameter int DIV_W = 5
) (
   input  wire logic             clk,      // Core clock
   input  wire logic             rst_n,    // Asynchronous reset, active low
   input  wire logic             run,      // Counting; low holds the count at zero
   input  wire logic             tick,     // Base clock enable pulse
   input  wire logic [DIV_W-1:0] div_k,    // Divider value k
   output logic                  sample,   // Pulse in the middle of a bit
   output logic                  bit_end   // Pulse at the end of a bit
);
   if (DIV_W < 2) begin : g_bad_div_w
      $error("bit_timer: DIV_W must be at least 2");
   end

   logic [DIV_W:0] cnt;
   wire  [DIV_W:0] half_last = {1'b0, div_k} - {{DIV_W{1'b0}}, 1'b1};
   wire  [DIV_W:0] full_last = {div_k, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
   wire            at_full   = (cnt == full_last);

   // One bit spans two divider periods, so the bit rate is the divider output over two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (!run) begin
         cnt <= '0;
      end else if (tick) begin
         cnt <= at_full ? '0 : cnt + {{DIV_W{1'b0}}, 1'b1};
      end
   end

   assign sample  = run & tick & (cnt == half_last);
   assign bit_end = run & tick & at_full;
endmodule // bit_timer

// ### logic/async_serial_unit.sv
// Asynchronous serial port core: mode register, transmitter, receiver and error status.
module async_serial_unit (
   input  wire logic        core_clk,          // Core clock, 250 MHz
   input  wire logic        nrst,              // System reset, active low
   input  wire logic        base_tick,         // Base clock enable pulse
   input  wire logic [4:0]  div_k,             // Five-bit divider value, 8 to 31
   input  wire logic [15:0] reg_addr,          // CPU register address
   input  wire logic        reg_wr,            // CPU write strobe
   input  wire logic        reg_rd,            // CPU read strobe
   input  wire logic [7:0]  reg_wdata,         // CPU write data
   output logic      [7:0]  reg_rdata,         // CPU read data, valid after read
   input  wire logic        serial_in_pin,     // Receive data line
   output logic             serial_out_pin,    // Transmit data line
   output logic             transmit_done_irq, // Pulse when a frame has been sent
   output logic             receive_done_irq,  // Pulse when a character is stored
   output logic             receive_error_irq  // Pulse when a reception error occurs
);
   ////////////////////////////////////////////////////////////////////////////////
   // Reset release and power gating

   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   logic [7:0] serial_mode_control;

   wire power_gate = serial_mode_control[async_serial_pkg::POWER_BIT];
   // Power gate off resets everything but the mode and read data registers, with no clock needed
   wire unit_rst_n = rst_sync & power_gate;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode

   wire at_mode   = (reg_addr == async_serial_pkg::MODE_ADDR);
   wire at_data   = (reg_addr == async_serial_pkg::DATA_ADDR);
   wire at_status = (reg_addr == async_serial_pkg::STATUS_ADDR);

   wire wr_mode   = reg_wr & at_mode;
   wire wr_tx     = reg_wr & at_data;
   wire rd_rxbuf  = reg_rd & at_data;
   wire rd_status = reg_rd & at_status;

   wire [1:0] par_sel  = serial_mode_control[async_serial_pkg::PAR_HI:async_serial_pkg::PAR_LO];
   wire       clen     = serial_mode_control[async_serial_pkg::CLEN_BIT];
   wire       two_stop = serial_mode_control[async_serial_pkg::STOP_BIT];
   wire       par_on   = (par_sel != async_serial_pkg::PAR_NONE);
   wire [3:0] char_len = clen ? async_serial_pkg::LEN_EIGHT
                              : async_serial_pkg::LEN_SEVEN;

   // Bit 0 is kept as written; software is expected to write one there
   always_ff @(posedge core_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         serial_mode_control <= async_serial_pkg::MODE_RESET;
      end else if (wr_mode) begin
         serial_mode_control <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Enables, taken over at the base clock

   logic tx_en;
   logic rx_en;

   // A change of an enable bit acts only at the next base tick
   always_ff @(posedge core_clk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         tx_en <= 1'b0;
         rx_en <= 1'b0;
      end else if (base_tick) begin
         tx_en <= serial_mode_control[async_serial_pkg::TXE_BIT];
         rx_en <= serial_mode_control[async_serial_pkg::RXE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter

   typedef enum logic {TX_IDLE, TX_BUSY} tx_state_t;

   tx_state_t                             tx_state;
   logic [7:0]                            transmit_shift;
   logic [async_serial_pkg::FRAME_W-1:0]  tx_frame;
   logic [async_serial_pkg::BITS_W-1:0]   tx_left;
   logic                                  tx_bit_end;

   wire [7:0] tx_data = clen ? reg_wdata : {1'b0, reg_wdata[6:0]};
   wire       tx_odd  = ~^tx_data;
   wire       tx_even = ^tx_data;

   logic tx_par;
   always_comb begin
      case (par_sel)
         async_serial_pkg::PAR_ZERO: tx_par = 1'b0;
         async_serial_pkg::PAR_ODD:  tx_par = tx_odd;
         async_serial_pkg::PAR_EVEN: tx_par = tx_even;
         default:                    tx_par = 1'b1;
      endcase
   end

   // Start bit low, data LSB first, optional parity, then ones for stop and idle
   wire [async_serial_pkg::FRAME_W-1:0] frame_eight = {2'b11, tx_par, tx_data, 1'b0};
   wire [async_serial_pkg::FRAME_W-1:0] frame_seven = {3'b111, tx_par, tx_data[6:0], 1'b0};
   wire [async_serial_pkg::FRAME_W-1:0] next_frame  = clen ? frame_eight : frame_seven;

   // Bits still to go after the start bit: data, parity, then one or two stops
   wire [async_serial_pkg::BITS_W-1:0] next_left =
      char_len + {3'b000, par_on} + {3'b000, two_stop} + 4'h1;

   // Writes during a frame or with transmit disabled are not taken
   wire tx_start = wr_tx & tx_en & (tx_state == TX_IDLE);

   bit_timer #(
      .DIV_W   (async_serial_pkg::DIV_W)
   ) tx_timer (
      .clk     (core_clk),
      .rst_n   (unit_rst_n),
      .run     (tx_state == TX_BUSY),
      .tick    (base_tick),
      .div_k   (div_k),
      .sample  (),
      .bit_end (tx_bit_end)
   );

   always_ff @(posedge core_clk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         tx_state          <= TX_IDLE;
         transmit_shift    <= async_serial_pkg::TXSHIFT_RESET;
         tx_frame          <= '1;
         tx_left           <= '0;
         serial_out_pin    <= 1'b1;
         transmit_done_irq <= 1'b0;
      end else if (!tx_en) begin
         tx_state          <= TX_IDLE;
         transmit_shift    <= async_serial_pkg::TXSHIFT_RESET;
         tx_frame          <= '1;
         tx_left           <= '0;
         serial_out_pin    <= 1'b1;
         transmit_done_irq <= 1'b0;
      end else begin
         transmit_done_irq <= 1'b0;
         case (tx_state)
            TX_IDLE: begin
               if (tx_start) begin
                  transmit_shift <= reg_wdata;
                  tx_frame       <= {1'b1, next_frame[async_serial_pkg::FRAME_W-1:1]};
                  tx_left        <= next_left;
                  serial_out_pin <= next_frame[0];
                  tx_state       <= TX_BUSY;
               end
            end
            TX_BUSY: begin
               if (tx_bit_end) begin
                  if (tx_left == '0) begin
                     tx_state          <= TX_IDLE;
                     transmit_done_irq <= 1'b1;
                  end else begin
                     serial_out_pin <= tx_frame[0];
                     tx_frame       <= {1'b1, tx_frame[async_serial_pkg::FRAME_W-1:1]};
                     tx_left        <= tx_left - 4'h1;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver

   typedef enum logic {RX_IDLE, RX_ACTIVE} rx_state_t;

   rx_state_t                           rx_state;
   logic [7:0]                          receive_shifter;
   logic [7:0]                          receive_buffer;
   logic [2:0]                          receive_error_status;
   logic [async_serial_pkg::BITS_W-1:0] rx_idx;
   logic                                rx_par_bit;
   logic                                rx_full;
   logic                                rx_sample;

   // The pin is ignored while the power gate is off
   wire rx_line = power_gate ? serial_in_pin : 1'b1;

   wire [async_serial_pkg::BITS_W-1:0] par_idx  = char_len + 4'h1;
   wire [async_serial_pkg::BITS_W-1:0] stop_idx = par_idx + {3'b000, par_on};

   wire in_data  = (rx_idx != '0) && (rx_idx <= char_len);
   wire at_par   = par_on && (rx_idx == par_idx);
   wire at_stop  = (rx_idx == stop_idx);
   wire rx_done  = (rx_state == RX_ACTIVE) & rx_sample & at_stop;

   // Seven-bit characters end up in the upper shifter bits and are moved down
   wire [7:0] rx_word = clen ? receive_shifter : {1'b0, receive_shifter[7:1]};
   wire       par_sum = (^rx_word) ^ rx_par_bit;

   // Zero parity is never judged
   wire rx_pe  = ((par_sel == async_serial_pkg::PAR_ODD) & ~par_sum) |
                 ((par_sel == async_serial_pkg::PAR_EVEN) & par_sum);
   wire rx_fe  = ~rx_line;
   wire rx_ove = rx_full;
   wire [2:0] rx_errs = {rx_pe, rx_fe, rx_ove};

   // A low line at enable starts a frame at once; no idle-high qualification
   wire rx_begin = rx_en & (rx_state == RX_IDLE) & ~rx_line;

   bit_timer #(
      .DIV_W   (async_serial_pkg::DIV_W)
   ) rx_timer (
      .clk     (core_clk),
      .rst_n   (unit_rst_n),
      .run     (rx_state == RX_ACTIVE),
      .tick    (base_tick),
      .div_k   (div_k),
      .sample  (rx_sample),
      .bit_end ()
   );

   always_ff @(posedge core_clk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         rx_state        <= RX_IDLE;
         rx_idx          <= '0;
         receive_shifter <= '0;
         rx_par_bit      <= 1'b0;
      end else if (!rx_en) begin
         rx_state        <= RX_IDLE;
         rx_idx          <= '0;
         receive_shifter <= '0;
         rx_par_bit      <= 1'b0;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               if (rx_begin) begin
                  rx_state <= RX_ACTIVE;
                  rx_idx   <= '0;
               end
            end
            RX_ACTIVE: begin
               if (rx_sample) begin
                  rx_idx <= rx_idx + 4'h1;
                  // A start bit that is high at mid-bit was a glitch
                  if ((rx_idx == '0) && rx_line) begin
                     rx_state <= RX_IDLE;
                  end else if (in_data) begin
                     receive_shifter <= {rx_line, receive_shifter[7:1]};
                  end else if (at_par) begin
                     rx_par_bit <= rx_line;
                  end else if (at_stop) begin
                     rx_state <= RX_IDLE;
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // Buffer and full flag: a read clears full, a new load in the same cycle wins
   always_ff @(posedge core_clk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         receive_buffer <= async_serial_pkg::RXBUF_RESET;
         rx_full        <= 1'b0;
      end else begin
         if (rx_done && !rx_ove) begin
            receive_buffer <= rx_word;
         end
         if (!rx_en) begin
            rx_full <= 1'b0;
         end else if (rx_done && !rx_ove) begin
            rx_full <= 1'b1;
         end else if (rd_rxbuf) begin
            rx_full <= 1'b0;
         end
      end
   end

   // Error flags: set wins over the read that clears them
   always_ff @(posedge core_clk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         receive_error_status <= async_serial_pkg::STATUS_RESET[2:0];
         receive_done_irq     <= 1'b0;
         receive_error_irq    <= 1'b0;
      end else if (!rx_en) begin
         receive_error_status <= async_serial_pkg::STATUS_RESET[2:0];
         receive_done_irq     <= 1'b0;
         receive_error_irq    <= 1'b0;
      end else begin
         receive_done_irq  <= rx_done & ~rx_ove;
         receive_error_irq <= rx_done & (|rx_errs);
         if (rx_done) begin
            receive_error_status <= (rd_status ? 3'h0 : receive_error_status) | rx_errs;
         end else if (rd_status) begin
            receive_error_status <= 3'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data

   wire [7:0] status_word = {5'h00, receive_error_status};
   wire [7:0] read_mux =
      at_mode   ? serial_mode_control :
      at_data   ? receive_buffer :
      at_status ? status_word : async_serial_pkg::READ_NONE;

   always_ff @(posedge core_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         reg_rdata <= async_serial_pkg::READ_NONE;
      end else if (reg_rd) begin
         reg_rdata <= read_mux;
      end
   end
endmodule // async_serial_unit

// ### verif/async_serial_asserts.sv
// Port-level assertions for the asynchronous serial port core.
module async_serial_asserts (
   input wire logic        core_clk,          // Core clock
   input wire logic        nrst,              // System reset, active low
   input wire logic        base_tick,         // Base clock enable
   input wire logic [4:0]  div_k,             // Divider value
   input wire logic [15:0] reg_addr,          // CPU address
   input wire logic        reg_wr,            // Write strobe
   input wire logic        reg_rd,            // Read strobe
   input wire logic [7:0]  reg_wdata,         // Write data
   input wire logic [7:0]  reg_rdata,         // Read data
   input wire logic        serial_in_pin,     // Receive line
   input wire logic        serial_out_pin,    // Transmit line
   input wire logic        transmit_done_irq, // Frame sent
   input wire logic        receive_done_irq,  // Character stored
   input wire logic        receive_error_irq  // Reception error
);
   logic [7:0] mode;
   logic [1:0] txe_d;
   logic       busy;
   wire        tx_wr = reg_wr && reg_addr == 16'hff72;
   // A write only counts once the enable has had time to pass its sync stage
   wire        tx_ok = tx_wr && mode[7] && mode[6] && (&txe_d) && !busy;
   wire        rd_buf = reg_rd && reg_addr == 16'hff72;
   wire        rd_st = reg_rd && reg_addr == 16'hff73;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode <= 8'h01;
         txe_d <= 2'h0;
         busy <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 16'hff70) mode <= reg_wdata;
         txe_d <= {txe_d[0], mode[6] & mode[7]};
         busy <= tx_ok | (busy & !transmit_done_irq & mode[6] & mode[7]);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_tx_start_low: assert property (tx_ok |-> ##[1:2] !serial_out_pin)
      else $error("no start bit after transmit write");
   a_tx_off_idle: assert property ((!mode[6]) [*3] |-> serial_out_pin)
      else $error("line not idle with transmitter off");
   a_power_off_idle: assert property (!mode[7] |=> serial_out_pin)
      else $error("line not idle with power gate off");
   a_done_stop_high: assert property (transmit_done_irq |-> serial_out_pin && $past(serial_out_pin, 8))
      else $error("frame ended without high stop");
   a_done_pulse: assert property (transmit_done_irq |=> !transmit_done_irq)
      else $error("transmit done longer than one cycle");
   a_rx_off_quiet: assert property ((!(mode[5] && mode[7])) [*4] |-> !receive_done_irq && !receive_error_irq)
      else $error("receive event with receiver off");
   a_mode_readback: assert property (reg_rd && reg_addr == 16'hff70 |=> reg_rdata == mode)
      else $error("mode register readback wrong");
   a_buf_power_off: assert property (rd_buf && !mode[7] |=> reg_rdata == 8'hff)
      else $error("receive buffer not all ones when gated");
   a_status_power_off: assert property (rd_st && !mode[7] |=> reg_rdata == 8'h00)
      else $error("status not clear when gated");
   a_status_upper_zero: assert property (rd_st |=> reg_rdata[7:3] == 5'h00)
      else $error("status upper bits not zero");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   c_tx_done: cover property (transmit_done_irq);
   c_rx_done: cover property (receive_done_irq);
   c_rx_error: cover property (receive_error_irq);
endmodule // async_serial_asserts

bind async_serial_unit async_serial_asserts chk (
   .core_clk(core_clk), .nrst(nrst), .base_tick(base_tick), .div_k(div_k),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
   .transmit_done_irq(transmit_done_irq), .receive_done_irq(receive_done_irq),
   .receive_error_irq(receive_error_irq));

// ### verif/remote_serial_peer.sv
// Behavioural remote serial device on the transmit and receive lines.
module remote_serial_peer #(
   parameter int BIT = 16 // Core cycles per bit
) (
   input  wire logic clk,     // Core clock
   input  wire logic line_in, // From the core's transmit pin
   output logic      line_out // To the core's receive pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line_out = 1'b1;

   function automatic logic par_bit(int pm, logic [7:0] d, int nb);
      logic x;
      x = ^(nb == 8 ? d : {1'b0, d[6:0]});
      return pm == 2 ? !x : (pm == 3 ? x : 1'b0);
   endfunction

   // Called at a falling edge; a bad stop leaves the line low for a whole bit
   task automatic send(logic [7:0] d, int nb, int pm, logic bad_par, logic bad_stop);
      logic q[$];
      q.push_back(1'b0);
      for (int i = 0; i < nb; i++) q.push_back(d[i]);
      if (pm != 0) q.push_back(par_bit(pm, d, nb) ^ bad_par);
      q.push_back(!bad_stop);
      foreach (q[i]) begin
         line_out = q[i];
         repeat (BIT) @(negedge clk);
      end
      line_out = 1'b1;
   endtask

   task automatic recv(int nb, logic np, output logic [7:0] d, output logic p,
                       output logic s);
      int n;
      n = 0;
      d = 8'h00;
      p = 1'b0;
      while (line_in && n < 4000) begin
         @(negedge clk);
         n++;
      end
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < nb; i++) begin
         repeat (BIT) @(negedge clk);
         d[i] = line_in;
      end
      if (np) begin
         repeat (BIT) @(negedge clk);
         p = line_in;
      end
      repeat (BIT) @(negedge clk);
      s = line_in;
   endtask
endmodule // remote_serial_peer

// ### verif/async_serial_unit_tb.sv
// Self-checking bench for the asynchronous serial port core.
module async_serial_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        base_tick = 1'b1;
   logic [4:0]  div_k = 5'h08;
   logic [15:0] reg_addr = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic        serial_in_pin;
   logic        serial_out_pin;
   logic        transmit_done_irq;
   logic        receive_done_irq;
   logic        receive_error_irq;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          rx_irqs = 0;
   int          err_irqs = 0;
   int          pm, nb, sl, n;
   logic [7:0]  m, tx, rx, got;
   logic        gp, gs;

   always #2 core_clk = ~core_clk;

   async_serial_unit dut (
      .core_clk(core_clk), .nrst(nrst), .base_tick(base_tick), .div_k(div_k),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .transmit_done_irq(transmit_done_irq),
      .receive_done_irq(receive_done_irq), .receive_error_irq(receive_error_irq));

   // Base tick held high: one bit is 2*k = 16 core cycles
   remote_serial_peer #(.BIT(16)) peer (
      .clk(core_clk), .line_in(serial_out_pin), .line_out(serial_in_pin));

   task automatic finish_test();
      if (fail_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         finish_test();
      end
   end

   // Event pulses are counted away from the launching edge
   always @(negedge core_clk) begin
      if (receive_done_irq === 1'b1) rx_irqs++;
      if (receive_error_irq === 1'b1) err_irqs++;
   end

   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(logic [15:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   task automatic rdc(string what, logic [15:0] a, logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(what, v, exp);
   endtask

   // Power on with enables off, let them settle, then enable both halves
   task automatic setup(logic [7:0] md);
      wr(16'hff70, md);
      repeat (3) @(negedge core_clk);
      wr(16'hff70, md | 8'h60);
      repeat (2) @(negedge core_clk);
   endtask

   initial begin
      void'($urandom(32'h5029));
      repeat (8) @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
      rdc("mode reset", 16'hff70, 8'h01);
      rdc("rx buffer reset", 16'hff72, 8'hff);
      rdc("status reset", 16'hff73, 8'h00);
      rdc("unmapped read", 16'hff74, 8'h00);
      wr(16'hff72, 8'h00);
      rdc("rx buffer kept", 16'hff72, 8'hff);
      for (int c = 0; c < 16; c++) begin
         pm = (c >> 2) & 3;
         nb = (c & 2) != 0 ? 8 : 7;
         sl = c & 1;
         m = 8'h81 | 8'(c << 1);
         setup(m);
         tx = 8'($urandom);
         rx = 8'($urandom);
         n = 0;
         fork
            begin
               wr(16'hff72, tx);
               while (!transmit_done_irq && n < 4000) begin
                  @(negedge core_clk);
                  n++;
               end
            end
            peer.recv(nb, pm != 0, got, gp, gs);
            peer.send(rx, nb, pm, pm == 1, 1'b0);
         join
         chk("tx data", got, nb == 8 ? tx : tx & 8'h7f);
         chk("tx parity", 8'(gp), 8'(peer.par_bit(pm, tx, nb)));
         chk("tx stop", 8'(gs), 8'h01);
         chk("tx frame bits", 8'((n + 8) / 16), 8'(2 + nb + (pm != 0) + sl));
         rdc("rx status", 16'hff73, 8'h00);
         rdc("rx data", 16'hff72, nb == 8 ? rx : rx & 8'h7f);
      end
      setup(8'h95);
      peer.send(8'h3c, 8, 2, 1'b1, 1'b0);
      rdc("parity error", 16'hff73, 8'h04);
      rd(16'hff72, got);
      peer.send(8'h55, 8, 2, 1'b0, 1'b1);
      repeat (32) @(negedge core_clk);
      rdc("framing error", 16'hff73, 8'h02);
      rd(16'hff72, got);
      peer.send(8'ha1, 8, 2, 1'b0, 1'b0);
      @(negedge core_clk);
      peer.send(8'hb2, 8, 2, 1'b0, 1'b0);
      rdc("overrun flag", 16'hff73, 8'h01);
      rdc("overrun keeps buffer", 16'hff72, 8'ha1);
      peer.send(8'h3c, 8, 2, 1'b1, 1'b0);
      wr(16'hff70, 8'hd5);
      repeat (3) @(negedge core_clk);
      rdc("status after rx off", 16'hff73, 8'h00);
      wr(16'hff70, 8'h95);
      wr(16'hff70, 8'h01);
      rdc("buffer after power off", 16'hff72, 8'hff);
      // Sixteen clean characters plus four stored ones; four frames carried errors
      chk("rx done pulses", 8'(rx_irqs), 8'h14);
      chk("rx error pulses", 8'(err_irqs), 8'h04);
      finish_test();
   end
endmodule // async_serial_unit_tb
